// ==== rtl/csw_top.sv ====
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
// Contract
// - Expansion alarm bit n is 1 while unit n+1 has heater burnout, overcurrent or shorted relay, else 0.
// - For a unit of the alternative regulator type an open relay also raises its alarm bit.
// - Output word bits 0 to 3 mirror control outputs 1 to 4, 1 meaning on.
// - On linear-output variants bits 0 and 1 of the output word are unsupported.
// - Storage word bit 0 is 1 when a save of the first backup area was cut by power loss.
// - Storage word bit 1 is 1 when a save of the second backup area was cut by power loss.
// - Storage word bit 2 is 1 when parameter storing after autotuning was cut by power loss.
// - Storage word bit 3 is 1 when storing the unit configuration or read list was cut.
// - Storage word bit 8 is 0 for backup write mode and 1 for RAM-only write mode.
// - Storage word bit 9 is 0 when RAM equals nonvolatile memory and 1 when they differ.
// - Storage word bit 12 is 1 once a unit configuration is registered, else 0.
module csw_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [csw_pkg::ADDR_W-1:0] paddr,
    input wire logic [csw_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [csw_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Expansion unit fault lines
    input wire csw_pkg::csw_unit_fault_t unit_fault,
    // Control output states
    input wire logic [csw_pkg::OUTPUTS-1:0] ctrl_out,
    // Storage and save state lines
    input wire csw_pkg::csw_store_t store_state,
    // Variant strap, high for linear outputs
    input wire logic linear_outputs
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser
    // Every pin bit is synchronised on its own. A multi-bit change may
    // land split over one cycle, which is harmless here because each
    // status bit stands alone. No word is assembled across the pins.
    // The price is three edges of latency from pin to word.

    csw_pkg::csw_pins_t pins_meta;
    csw_pkg::csw_pins_t pins_sync;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pins_meta <= '0;
            pins_sync <= '0;
        end else begin
            pins_meta <= {unit_fault, ctrl_out, store_state, linear_outputs};
            pins_sync <= pins_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Variant strap, caught once the synchroniser holds a real sample
    // Taken once, so a strap that bounces later cannot flip the
    // meaning of the output word; a change needs a reset

    logic [1:0] strap_cnt;
    logic linear_cfg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt <= 2'h0;
        end else if (strap_cnt != csw_pkg::STRAP_CNT_DONE) begin
            strap_cnt <= strap_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            linear_cfg <= 1'b0;
        end else if (strap_cnt == csw_pkg::STRAP_CNT_TAKE) begin
            linear_cfg <= pins_sync.linear_outputs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Expansion unit alarm word

    logic [csw_pkg::UNITS-1:0] next_alarm;
    logic [csw_pkg::WORD_W-1:0] alarm_word;

    genvar u;
    generate
        for (u = 0; u < csw_pkg::UNITS; u++) begin : g_unit
            always_comb begin
                next_alarm[u] = pins_sync.unit.heater_burnout[u]
                    | pins_sync.unit.overcurrent[u]
                    | pins_sync.unit.ssr_short[u];
                if (pins_sync.unit.regulator_type[u]) begin
                    next_alarm[u] = next_alarm[u]
                        | pins_sync.unit.ssr_open[u];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            alarm_word <= csw_pkg::RST_WORD;
        end else begin
            // Upper byte never set
            alarm_word <= {8'h00, next_alarm};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control output word

    logic [csw_pkg::OUTPUTS-1:0] next_outputs;
    logic [csw_pkg::WORD_W-1:0] output_word;

    always_comb begin
        next_outputs = pins_sync.ctrl_out;
        // Linear outputs carry no on/off state; report off
        if (linear_cfg) begin
            next_outputs[csw_pkg::POS_LINEAR_LO] = 1'b0;
            next_outputs[csw_pkg::POS_LINEAR_HI] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            output_word <= csw_pkg::RST_WORD;
        end else begin
            output_word <= {12'h000, next_outputs};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage and save state word

    logic [csw_pkg::WORD_W-1:0] next_store;
    logic [csw_pkg::WORD_W-1:0] store_word;

    always_comb begin
        next_store = 16'h0000;
        next_store[csw_pkg::POS_SAVE_AREA1] =
            pins_sync.store.first_backup_area_torn;
        next_store[csw_pkg::POS_SAVE_AREA2] =
            pins_sync.store.second_backup_area_torn;
        next_store[csw_pkg::POS_SAVE_PARAM] =
            pins_sync.store.param_store_torn;
        next_store[csw_pkg::POS_SAVE_CONFIG] =
            pins_sync.store.config_store_torn;
        next_store[csw_pkg::POS_WRITE_MODE] =
            pins_sync.store.ram_write_mode;
        next_store[csw_pkg::POS_RAM_DIFFERS] =
            pins_sync.store.ram_differs;
        next_store[csw_pkg::POS_CONFIG_REG] =
            pins_sync.store.config_registered;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            store_word <= csw_pkg::RST_WORD;
        end else begin
            store_word <= next_store;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events: rising edges of the latched words
    // Edges are taken from the registered words, not the pins, so an
    // event never fires before the host could read the new level

    logic [csw_pkg::WORD_W-1:0] alarm_prev;
    logic [csw_pkg::WORD_W-1:0] store_prev;
    logic [csw_pkg::WORD_W-1:0] event_set;
    logic save_err_now;
    logic save_err_prev;

    assign save_err_now = |store_word[csw_pkg::POS_SAVE_CONFIG:0];
    assign save_err_prev = |store_prev[csw_pkg::POS_SAVE_CONFIG:0];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            alarm_prev <= csw_pkg::RST_WORD;
            store_prev <= csw_pkg::RST_WORD;
        end else begin
            alarm_prev <= alarm_word;
            store_prev <= store_word;
        end
    end

    always_comb begin
        event_set = alarm_word & ~alarm_prev;
        event_set[csw_pkg::POS_EV_SAVE] = save_err_now & ~save_err_prev;
        event_set[csw_pkg::POS_EV_DIFF] =
            store_word[csw_pkg::POS_RAM_DIFFERS]
            & ~store_prev[csw_pkg::POS_RAM_DIFFERS];
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    // Read data is captured at the setup edge; the read-clear of the
    // event word acts one edge later, at the access edge

    logic setup_phase;
    logic access_done;
    logic rd_done;
    logic wr_done;
    logic addr_hit;
    logic [csw_pkg::DATA_W-1:0] next_rdata;

    assign setup_phase = psel & ~penable;
    // pready is only ever high during the access phase
    assign access_done = psel & penable & pready;
    assign rd_done = access_done & ~pwrite;
    assign wr_done = access_done & pwrite;

    logic [csw_pkg::WORD_W-1:0] event_status;
    logic [csw_pkg::WORD_W-1:0] event_mask;

    always_comb begin
        addr_hit = 1'b1;
        next_rdata = csw_pkg::RST_DATA;
        unique case (paddr)
            csw_pkg::ADDR_ALARM: next_rdata = {16'h0000, alarm_word};
            csw_pkg::ADDR_OUTPUT: next_rdata = {16'h0000, output_word};
            csw_pkg::ADDR_STORE: next_rdata = {16'h0000, store_word};
            csw_pkg::ADDR_EVENT: next_rdata = {16'h0000, event_status};
            csw_pkg::ADDR_MASK: next_rdata = {16'h0000, event_mask};
            default: addr_hit = 1'b0;
        endcase
        if (pwrite) begin
            next_rdata = csw_pkg::RST_DATA;
        end
    end

    // No wait state; prdata still comes straight from a flop loaded at the setup edge
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= csw_pkg::RST_DATA;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~addr_hit;
            if (setup_phase) begin
                prdata <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output

    logic read_clear;
    logic mask_write;

    assign read_clear = rd_done & (paddr == csw_pkg::ADDR_EVENT);
    // Status words reject writes silently; only the mask takes one
    assign mask_write = wr_done & (paddr == csw_pkg::ADDR_MASK);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            event_status <= csw_pkg::RST_WORD;
        end else if (read_clear) begin
            // Clear only what the host saw; events set after the
            // setup edge were not in prdata and must survive
            event_status <= (event_status & ~prdata[csw_pkg::WORD_W-1:0])
                | event_set;
        end else begin
            event_status <= event_status | event_set;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            event_mask <= csw_pkg::RST_MASK;
        end else if (mask_write) begin
            if (pstrb[0]) begin
                event_mask[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                event_mask[15:8] <= pwdata[15:8];
            end
        end
    end

    // Registered so the pin never glitches; costs one cycle of delay
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_status & event_mask);
        end
    end

endmodule : csw_top

// ==== rtl/csw_pkg.sv ====
package csw_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned UNITS = 8;
    localparam int unsigned OUTPUTS = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register indices and byte addresses (byte address = 4 * index)
    localparam logic [ADDR_W-1:0] IDX_ALARM = 8'h10;
    localparam logic [ADDR_W-1:0] IDX_OUTPUT = 8'h12;
    localparam logic [ADDR_W-1:0] IDX_STORE = 8'h13;
    localparam logic [ADDR_W-1:0] IDX_EVENT = 8'h14;
    localparam logic [ADDR_W-1:0] IDX_MASK = 8'h15;
    localparam logic [ADDR_W-1:0] ADDR_ALARM = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_OUTPUT = 8'h48;
    localparam logic [ADDR_W-1:0] ADDR_STORE = 8'h4C;
    localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h54;

    ////////////////////////////////////////////////////////////////////////
    // Field positions of the storage and save state word
    localparam int unsigned POS_SAVE_AREA1 = 0;
    localparam int unsigned POS_SAVE_AREA2 = 1;
    localparam int unsigned POS_SAVE_PARAM = 2;
    localparam int unsigned POS_SAVE_CONFIG = 3;
    localparam int unsigned POS_WRITE_MODE = 8;
    localparam int unsigned POS_RAM_DIFFERS = 9;
    localparam int unsigned POS_CONFIG_REG = 12;
    // Positions of the linear-output unsupported bits
    localparam int unsigned POS_LINEAR_LO = 0;
    localparam int unsigned POS_LINEAR_HI = 1;

    ////////////////////////////////////////////////////////////////////////
    // Event status layout: bits 7..0 unit alarm rise, 8 save error rise,
    // 9 RAM/nonvolatile mismatch rise
    localparam int unsigned POS_EV_SAVE = 8;
    localparam int unsigned POS_EV_DIFF = 9;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
    localparam logic [WORD_W-1:0] RST_MASK = 16'h0000;
    localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
    localparam logic [1:0] STRAP_CNT_TAKE = 2'h2;
    localparam logic [1:0] STRAP_CNT_DONE = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [UNITS-1:0] heater_burnout;
        logic [UNITS-1:0] overcurrent;
        logic [UNITS-1:0] ssr_short;
        logic [UNITS-1:0] ssr_open;
        logic [UNITS-1:0] regulator_type;
    } csw_unit_fault_t;

    typedef struct packed {
        logic first_backup_area_torn;
        logic second_backup_area_torn;
        logic param_store_torn;
        logic config_store_torn;
        logic ram_write_mode;
        logic ram_differs;
        logic config_registered;
    } csw_store_t;

    typedef struct packed {
        csw_unit_fault_t unit;
        logic [OUTPUTS-1:0] ctrl_out;
        csw_store_t store;
        logic linear_outputs;
    } csw_pins_t;

endpackage : csw_pkg

// ==== verif/csw_top_chk.sv ====
`timescale 1ns/10ps
module csw_top_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [csw_pkg::ADDR_W-1:0] paddr,
    input wire logic [csw_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Status pins
    input wire csw_pkg::csw_unit_fault_t unit_fault,
    input wire logic [csw_pkg::OUTPUTS-1:0] ctrl_out,
    input wire csw_pkg::csw_store_t store_state,
    input wire logic linear_outputs
);
    logic [2:0] calm;
    logic [51:0] pins;
    logic [51:0] pins_q;
    logic rd_setup;
    logic mapped;
    logic [7:0] alarm;
    csw_pkg::csw_store_t s;
    assign pins = {unit_fault, ctrl_out, store_state, linear_outputs};
    assign rd_setup = psel && !penable && !pwrite && calm >= 3'h4;
    assign mapped = paddr inside {csw_pkg::ADDR_ALARM, csw_pkg::ADDR_OUTPUT,
        csw_pkg::ADDR_STORE, csw_pkg::ADDR_EVENT, csw_pkg::ADDR_MASK};
    assign alarm = unit_fault.heater_burnout | unit_fault.overcurrent |
        unit_fault.ssr_short | (unit_fault.ssr_open & unit_fault.regulator_type);
    assign s = store_state;
    // Words lag the pins by three edges, so only judge quiet pins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            calm <= 3'h0;
            pins_q <= '0;
        end else begin
            pins_q <= pins;
            calm <= (pins != pins_q) ? 3'h0 : (calm == 3'h7 ? calm : calm + 3'h1);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    AST_UNMAPPED: assert property (psel && !penable && !mapped |=>
        pslverr && prdata == 32'h0000_0000) else $error("unmapped not refused");
    AST_MAPPED: assert property (psel && !penable && mapped |=> !pslverr)
        else $error("mapped access refused");
    AST_ALARM: assert property (rd_setup && paddr == csw_pkg::ADDR_ALARM |=>
        prdata == {24'h00_0000, $past(alarm)}) else $error("alarm word wrong");
    AST_OUTPUT: assert property (rd_setup && paddr == csw_pkg::ADDR_OUTPUT |=>
        prdata[15:0] == {12'h000, $past(ctrl_out) & {2'b11, {2{!linear_outputs}}}})
        else $error("output word wrong");
    AST_STORE: assert property (rd_setup && paddr == csw_pkg::ADDR_STORE |=>
        prdata[15:0] == $past({3'h0, s.config_registered, 2'h0, s.ram_differs,
        s.ram_write_mode, 4'h0, s.config_store_torn, s.param_store_torn,
        s.second_backup_area_torn, s.first_backup_area_torn}))
        else $error("storage word wrong");
endmodule : csw_top_chk

bind csw_top csw_top_chk chk (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_fault(unit_fault),
    .ctrl_out(ctrl_out), .store_state(store_state),
    .linear_outputs(linear_outputs));

// ==== verif/csw_host.sv ====
`timescale 1ns/10ps
module csw_host (
    // Clock
    input wire logic clk_sys,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int timeouts = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
    end
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) timeouts++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released bus shows junk, not the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : csw_host

// ==== verif/csw_top_tb.sv ====
`timescale 1ns/10ps
module csw_top_tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd;
    csw_pkg::csw_unit_fault_t unit_fault = '0;
    logic [3:0] ctrl_out = 4'h0;
    csw_pkg::csw_store_t store_state = '0;
    logic linear_outputs = 1'b0;
    int miscompares = 0;
    int n_checks = 0;
    always #25 clk_sys = ~clk_sys;
    csw_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .unit_fault(unit_fault), .ctrl_out(ctrl_out),
        .store_state(store_state), .linear_outputs(linear_outputs));
    csw_host host (.clk_sys(clk_sys), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0000_0000, rd, err);
        chk(what, exp, rd);
    endtask : rd_chk
    task settle;
        repeat (5) @(posedge clk_sys);
        // Look at registered outputs away from the launching edge
        @(negedge clk_sys);
    endtask : settle
    task do_reset(input logic lin);
        rst_b <= 1'b0;
        linear_outputs <= lin;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////
    task t_alarm;
        csw_pkg::csw_unit_fault_t f;
        for (int n = 0; n < 8; n++) begin
            for (int k = 0; k < 5; k++) begin
                f = '0;
                case (k)
                    0: f.heater_burnout[n] = 1'b1;
                    1: f.overcurrent[n] = 1'b1;
                    2: f.ssr_short[n] = 1'b1;
                    3: {f.ssr_open[n], f.regulator_type[n]} = 2'b11;
                    default: f.ssr_open[n] = 1'b1;
                endcase
                unit_fault <= f;
                settle();
                rd_chk("alarm", csw_pkg::ADDR_ALARM, k == 4 ? 0 : 32'h1 << n);
            end
        end
        unit_fault <= '0;
    endtask : t_alarm
    task t_outputs(input logic lin);
        for (int i = 0; i < 4; i++) begin
            ctrl_out <= 4'h1 << i;
            settle();
            rd_chk("outputs", csw_pkg::ADDR_OUTPUT, (lin && i < 2) ? 0 : 32'h1 << i);
        end
    endtask : t_outputs
    task t_store;
        int pos[7] = '{csw_pkg::POS_SAVE_AREA1, csw_pkg::POS_SAVE_AREA2,
            csw_pkg::POS_SAVE_PARAM, csw_pkg::POS_SAVE_CONFIG,
            csw_pkg::POS_WRITE_MODE, csw_pkg::POS_RAM_DIFFERS,
            csw_pkg::POS_CONFIG_REG};
        for (int b = 0; b < 7; b++) begin
            store_state <= 7'h40 >> b;
            settle();
            rd_chk("store", csw_pkg::ADDR_STORE, 32'h1 << pos[b]);
        end
    endtask : t_store
    task t_readonly;
        logic [7:0] a[3] = '{csw_pkg::ADDR_ALARM, csw_pkg::ADDR_OUTPUT,
            csw_pkg::ADDR_STORE};
        logic [31:0] e[3] = '{32'h0000_0000, 32'h0000_000a, 32'h0000_130f};
        unit_fault <= '0;
        ctrl_out <= 4'ha;
        store_state <= 7'h7f;
        settle();
        for (int i = 0; i < 3; i++) begin
            host.xfer(1'b1, a[i], 32'hffff_ffff, rd, err);
            chk("ro error", 32'h0, {31'h0, err});
            rd_chk("ro word", a[i], e[i]);
        end
        host.xfer(1'b0, 8'h44, 32'h0, rd, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
    endtask : t_readonly
    task t_irq;
        host.xfer(1'b1, csw_pkg::ADDR_MASK, 32'h0000_0001, rd, err);
        rd_chk("event flush", csw_pkg::ADDR_EVENT, 32'h0000_03ff);
        unit_fault.heater_burnout <= 8'h01;
        settle();
        chk("irq raised", 32'h1, {31'h0, irq});
        rd_chk("event", csw_pkg::ADDR_EVENT, 32'h0000_0001);
        settle();
        chk("irq cleared", 32'h0, {31'h0, irq});
        @(posedge clk_sys);
        unit_fault.heater_burnout <= 8'h03;
        settle();
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk("event masked", csw_pkg::ADDR_EVENT, 32'h0000_0002);
    endtask : t_irq
    ////////////////////////////////////////////////////////////////////////
    task finish_test;
        miscompares += host.timeouts;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    initial begin
        do_reset(1'b0);
        t_alarm();
        t_outputs(1'b0);
        t_store();
        t_readonly();
        t_irq();
        do_reset(1'b1);
        t_outputs(1'b1);
        finish_test();
    end
endmodule : csw_top_tb
